// [pkg/idec_regs.svh]
// Purpose: constants of the 14-bit instruction decoder
// Assumes: one instruction cycle is four core clock periods
// Notes: file addresses of the timer and the i/o port are local choices
`ifndef IDEC_REGS_SVH
`define IDEC_REGS_SVH
`define IDEC_PHASE_LAST 2'h3
`define IDEC_FADDR_MAX 7'h7F
`define IDEC_TIMER_ADDR 7'h01
`define IDEC_PORT_ADDR 7'h05
`define IDEC_NOP_WORD 14'h0000
`define IDEC_RET_LOW 7'h08
`define IDEC_RETI_LOW 7'h09
`define IDEC_SLEEP_LOW 7'h63
`define IDEC_WDT_LOW 7'h64
`define IDEC_BIT_ONE 8'h01
`endif

// [pkg/idec_pkg.sv]
// Purpose: types of the 14-bit instruction decoder
// Assumes: nothing beyond the constants header
// Notes: operation codes are internal encodings, not instruction bits
package idec_pkg;
   typedef enum logic [5:0] {
      IDEC_OP_NOP, IDEC_OP_ADD_WF, IDEC_OP_SUB_WF, IDEC_OP_AND_WF, IDEC_OP_OR_WF,
      IDEC_OP_XOR_WF, IDEC_OP_INC_F, IDEC_OP_DEC_F, IDEC_OP_INC_SZ, IDEC_OP_DEC_SZ,
      IDEC_OP_RL_C, IDEC_OP_RR_C, IDEC_OP_COMP_F, IDEC_OP_MOVE_F, IDEC_OP_STORE_W,
      IDEC_OP_CLR_F, IDEC_OP_CLR_W, IDEC_OP_SWAP_F, IDEC_OP_BIT_CLR, IDEC_OP_BIT_SET,
      IDEC_OP_TST_CLR, IDEC_OP_TST_SET, IDEC_OP_ADD_LW, IDEC_OP_SUB_LW, IDEC_OP_AND_LW,
      IDEC_OP_OR_LW, IDEC_OP_XOR_LW, IDEC_OP_LOAD_LW, IDEC_OP_RET_LIT, IDEC_OP_RET,
      IDEC_OP_RET_IRQ, IDEC_OP_CALL, IDEC_OP_JUMP, IDEC_OP_SLEEP, IDEC_OP_WDT_CLR
   } idec_op_t;
   typedef enum logic [1:0] {
      IDEC_CLS_BYTE = 2'h0, IDEC_CLS_BIT = 2'h1, IDEC_CLS_JUMP = 2'h2, IDEC_CLS_LIT = 2'h3
   } idec_cls_t;
   typedef enum logic [1:0] {IDEC_ST_EXEC = 2'h1, IDEC_ST_FLUSH = 2'h2} idec_state_t;
   typedef struct packed {
      idec_op_t op;
      logic wr_file;
      logic upd_c;
      logic upd_dc;
      logic upd_z;
      logic upd_topd;
      logic fixed2;
      logic skip_z;
      logic tst_clr;
      logic tst_set;
   } idec_dec_t;
endpackage

// [rtl/idec_decoder.sv]
// What this block does
// RQ1 - file address is low seven bits
// RQ2 - destination bit picks working or file
// RQ3 - three-bit field selects one register bit
// RQ4 - don't-care bits never change the decode
// RQ5 - and/or with file, zero flag only
// RQ6 - add/sub set carries and zero; xor zero
// RQ7 - inc/dec set zero; skip variants no flags
// RQ8 - skip-on-zero ops take two cycles if zero
// RQ9 - rotates through carry update carry only
// RQ10 - top bits 01 decode four bit ops
// RQ11 - bit tests take two cycles when skipping
// RQ12 - call or jump, eleven-bit target, two cycles
// RQ13 - or/and/xor literal, zero flag only
// RQ14 - literal subtract and add set all flags
// RQ15 - return with literal two cycles; load one
// RQ16 - return and interrupt return, two cycles
// RQ17 - standby word updates time-out, power-down
// RQ18 - watchdog clear updates time-out, power-down
// RQ19 - read-modify-write of port uses pin levels
// RQ20 - timer writes clear its assigned prescaler
// RQ21 - second cycle of two runs as nop
// RQ22 - instruction cycle spans four clocks
// RQ23 - store, clears, complement, move, swap decode
//
// Purpose: decodes fetched 14-bit words into operation, fields and flag updates
// Assumes: INSTR_WORD, RESULT_ZERO, TESTED_BIT stable at the last phase of a cycle
// Notes: decoded outputs stand for one whole instruction cycle
`timescale 1ns/1ps
`include "idec_regs.svh"
module idec_decoder (
   // clock and reset
   input wire logic CORE_CLK,
   input wire logic RST,
   // fetch and datapath feedback
   input wire logic [13:0] INSTR_WORD,
   input wire logic RESULT_ZERO,
   input wire logic TESTED_BIT,
   input wire logic PRESCALER_ON_TIMER,
   // decoded instruction
   output idec_pkg::idec_op_t OP_CODE,
   output idec_pkg::idec_cls_t OP_CLASS,
   output logic [6:0] FILE_ADDR,
   output logic DEST_FILE,
   output logic [7:0] BIT_MASK,
   output logic [7:0] LITERAL,
   output logic [10:0] TARGET,
   output logic UPD_CARRY,
   output logic UPD_DIGIT_CARRY,
   output logic UPD_ZERO,
   output logic UPD_TIME_OUT_POWER_DOWN,
   output logic LOAD_PC,
   // cycle control and side effects
   output logic CYCLE_START,
   output logic FLUSH_NOP,
   output logic USE_PIN_LEVELS,
   output logic CLEAR_PRESCALER
);
   import idec_pkg::*;

   ////////////////////////////////////////////////////////////////////////////////
   function automatic idec_dec_t idec_decode(input logic [13:0] w);
      idec_dec_t r;
      r = '0;
      r.op = IDEC_OP_NOP;
      case (w[13:12])
         2'h0: begin
            r.wr_file = w[7]; // RQ2
            case (w[11:8])
               4'h0: begin
                  if (w[7]) begin
                     r.op = IDEC_OP_STORE_W; // RQ23
                  end else if (w[6:0] == `IDEC_RET_LOW) begin
                     r.op = IDEC_OP_RET; // RQ16
                     r.fixed2 = 1'b1;
                  end else if (w[6:0] == `IDEC_RETI_LOW) begin
                     r.op = IDEC_OP_RET_IRQ; // RQ16
                     r.fixed2 = 1'b1;
                  end else if (w[6:0] == `IDEC_SLEEP_LOW) begin
                     r.op = IDEC_OP_SLEEP; // RQ17
                     r.upd_topd = 1'b1;
                  end else if (w[6:0] == `IDEC_WDT_LOW) begin
                     r.op = IDEC_OP_WDT_CLR; // RQ18
                     r.upd_topd = 1'b1;
                  end
               end
               4'h1: begin
                  // the low seven bits are don't-care for the working-register clear
                  r.op = w[7] ? IDEC_OP_CLR_F : IDEC_OP_CLR_W; // RQ23 RQ4
                  r.upd_z = 1'b1;
               end
               4'h2: begin
                  r.op = IDEC_OP_SUB_WF; // RQ6
                  {r.upd_c, r.upd_dc, r.upd_z} = 3'h7;
               end
               4'h3: begin
                  r.op = IDEC_OP_DEC_F; // RQ7
                  r.upd_z = 1'b1;
               end
               4'h4: begin
                  r.op = IDEC_OP_OR_WF; // RQ5
                  r.upd_z = 1'b1;
               end
               4'h5: begin
                  r.op = IDEC_OP_AND_WF; // RQ5
                  r.upd_z = 1'b1;
               end
               4'h6: begin
                  r.op = IDEC_OP_XOR_WF; // RQ6
                  r.upd_z = 1'b1;
               end
               4'h7: begin
                  r.op = IDEC_OP_ADD_WF; // RQ6
                  {r.upd_c, r.upd_dc, r.upd_z} = 3'h7;
               end
               4'h8: begin
                  r.op = IDEC_OP_MOVE_F; // RQ23
                  r.upd_z = 1'b1;
               end
               4'h9: begin
                  r.op = IDEC_OP_COMP_F; // RQ23
                  r.upd_z = 1'b1;
               end
               4'hA: begin
                  r.op = IDEC_OP_INC_F; // RQ7
                  r.upd_z = 1'b1;
               end
               4'hB: begin
                  r.op = IDEC_OP_DEC_SZ; // RQ7 RQ8
                  r.skip_z = 1'b1;
               end
               4'hC: begin
                  r.op = IDEC_OP_RR_C; // RQ9
                  r.upd_c = 1'b1;
               end
               4'hD: begin
                  r.op = IDEC_OP_RL_C; // RQ9
                  r.upd_c = 1'b1;
               end
               4'hE: r.op = IDEC_OP_SWAP_F; // RQ23
               default: begin
                  r.op = IDEC_OP_INC_SZ; // RQ7 RQ8
                  r.skip_z = 1'b1;
               end
            endcase
            // clear-working and the control words never touch a file register
            if (w[11:8] == 4'h0 || w[11:8] == 4'h1) begin
               r.wr_file = w[7];
            end
         end
         2'h1: begin
            case (w[11:10]) // RQ10
               2'h0: begin
                  r.op = IDEC_OP_BIT_CLR;
                  r.wr_file = 1'b1;
               end
               2'h1: begin
                  r.op = IDEC_OP_BIT_SET;
                  r.wr_file = 1'b1;
               end
               2'h2: begin
                  r.op = IDEC_OP_TST_CLR; // RQ11
                  r.tst_clr = 1'b1;
               end
               default: begin
                  r.op = IDEC_OP_TST_SET; // RQ11
                  r.tst_set = 1'b1;
               end
            endcase
         end
         2'h2: begin
            r.op = w[11] ? IDEC_OP_JUMP : IDEC_OP_CALL; // RQ12
            r.fixed2 = 1'b1;
         end
         default: begin
            if (w[11:10] == 2'h0) begin
               r.op = IDEC_OP_LOAD_LW; // RQ15 RQ4
            end else if (w[11:10] == 2'h1) begin
               r.op = IDEC_OP_RET_LIT; // RQ15
               r.fixed2 = 1'b1;
            end else if (w[11:9] == 3'h6) begin
               r.op = IDEC_OP_SUB_LW; // RQ14
               {r.upd_c, r.upd_dc, r.upd_z} = 3'h7;
            end else if (w[11:9] == 3'h7) begin
               r.op = IDEC_OP_ADD_LW; // RQ14
               {r.upd_c, r.upd_dc, r.upd_z} = 3'h7;
            end else if (w[11:8] == 4'h8) begin
               r.op = IDEC_OP_OR_LW; // RQ13
               r.upd_z = 1'b1;
            end else if (w[11:8] == 4'h9) begin
               r.op = IDEC_OP_AND_LW; // RQ13
               r.upd_z = 1'b1;
            end else if (w[11:8] == 4'hA) begin
               r.op = IDEC_OP_XOR_LW; // RQ13
               r.upd_z = 1'b1;
            end
         end
      endcase
      return r;
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   logic [1:0] phase_r;
   logic bnd;
   idec_state_t state_r;
   idec_state_t state_nxt;
   idec_dec_t dec_r;
   idec_dec_t dec_nxt;
   logic [13:0] word_r;
   logic [13:0] word_nxt;
   logic need2;

   assign bnd = (phase_r == `IDEC_PHASE_LAST);

   // four phases per instruction cycle
   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         phase_r <= 2'h0;
         CYCLE_START <= 1'b0;
      end else begin
         phase_r <= phase_r + 2'h1; // RQ22
         CYCLE_START <= bnd; // RQ22
      end
   end

   // skip outcomes are sampled late so the datapath result has settled
   assign need2 = dec_r.fixed2 | (dec_r.skip_z & RESULT_ZERO) | // RQ8 RQ12
                  (dec_r.tst_clr & ~TESTED_BIT) | (dec_r.tst_set & TESTED_BIT); // RQ11

   always_comb begin
      state_nxt = IDEC_ST_EXEC;
      word_nxt = INSTR_WORD;
      case (state_r)
         IDEC_ST_EXEC: begin
            if (need2) begin
               state_nxt = IDEC_ST_FLUSH; // RQ21
               word_nxt = `IDEC_NOP_WORD; // RQ21
            end
         end
         default: state_nxt = IDEC_ST_EXEC;
      endcase
      dec_nxt = idec_decode(word_nxt);
   end

   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         state_r <= IDEC_ST_EXEC;
         word_r <= `IDEC_NOP_WORD;
         dec_r <= '0;
         FLUSH_NOP <= 1'b0;
      end else if (bnd) begin
         state_r <= state_nxt;
         word_r <= word_nxt;
         dec_r <= dec_nxt;
         FLUSH_NOP <= (state_nxt == IDEC_ST_FLUSH);
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // operand fields, held for the whole cycle
   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         FILE_ADDR <= 7'h00;
         DEST_FILE <= 1'b0;
         BIT_MASK <= 8'h00;
         LITERAL <= 8'h00;
         TARGET <= 11'h000;
         USE_PIN_LEVELS <= 1'b0;
         CLEAR_PRESCALER <= 1'b0;
      end else if (bnd) begin
         FILE_ADDR <= word_nxt[6:0] & `IDEC_FADDR_MAX; // RQ1
         DEST_FILE <= dec_nxt.wr_file; // RQ2
         BIT_MASK <= (word_nxt[13:12] == 2'h1) ? (`IDEC_BIT_ONE << word_nxt[9:7]) : 8'h00; // RQ3
         LITERAL <= word_nxt[7:0];
         TARGET <= word_nxt[10:0]; // RQ12
         // a port written from itself must see the pins, not its latch
         USE_PIN_LEVELS <= dec_nxt.wr_file && word_nxt[6:0] == `IDEC_PORT_ADDR; // RQ19
         CLEAR_PRESCALER <= dec_nxt.wr_file && PRESCALER_ON_TIMER && // RQ20
                            word_nxt[6:0] == `IDEC_TIMER_ADDR;
      end
   end

   assign OP_CODE = dec_r.op;
   assign OP_CLASS = idec_cls_t'(word_r[13:12]);
   assign UPD_CARRY = dec_r.upd_c;
   assign UPD_DIGIT_CARRY = dec_r.upd_dc;
   assign UPD_ZERO = dec_r.upd_z;
   assign UPD_TIME_OUT_POWER_DOWN = dec_r.upd_topd;
   assign LOAD_PC = dec_r.fixed2;

   ////////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (RST);

   sequence s_flush_cycle;
      FLUSH_NOP[*4] ##1 !FLUSH_NOP;
   endsequence

   sequence s_exec_bnd;
      bnd && state_r == IDEC_ST_EXEC;
   endsequence

   a_cycle_four_clocks: assert property (CYCLE_START |=> !CYCLE_START[*3] ##1 CYCLE_START) // RQ22
      else $error("instruction cycle is not four clocks");
   a_jump_two_cycles: assert property (s_exec_bnd and dec_r.fixed2 |=> // RQ12
      FLUSH_NOP && OP_CODE == IDEC_OP_NOP)
      else $error("fixed two-cycle op not followed by nop");
   a_skip_nonzero_one: assert property (s_exec_bnd and dec_r.skip_z && !RESULT_ZERO |=> // RQ8
      !FLUSH_NOP)
      else $error("skip-on-zero flushed with nonzero result");
   a_test_clear_skip: assert property (s_exec_bnd and dec_r.tst_clr && !TESTED_BIT |=> // RQ11
      FLUSH_NOP)
      else $error("clear test did not skip");
   a_flush_length: assert property ($rose(FLUSH_NOP) |-> s_flush_cycle) // RQ21
      else $error("nop cycle is not one instruction cycle");
   a_dest_route: assert property (OP_CODE == IDEC_OP_ADD_WF |-> DEST_FILE == word_r[7]) // RQ2
      else $error("destination select wrong");
   a_zero_only: assert property (OP_CODE inside {IDEC_OP_AND_WF, IDEC_OP_OR_LW} |-> // RQ5
      UPD_ZERO && !UPD_CARRY && !UPD_DIGIT_CARRY)
      else $error("logic op flag set wrong");
   a_bit_mask: assert property (OP_CLASS == IDEC_CLS_BIT |-> // RQ3
      BIT_MASK == (`IDEC_BIT_ONE << word_r[9:7]))
      else $error("bit mask does not match bit field");
   a_prescaler_clr: assert property (CLEAR_PRESCALER |-> // RQ20
      FILE_ADDR == `IDEC_TIMER_ADDR && DEST_FILE)
      else $error("prescaler cleared off the timer");
   a_pin_levels: assert property (USE_PIN_LEVELS |-> FILE_ADDR == `IDEC_PORT_ADDR && DEST_FILE) // RQ19
      else $error("pin levels used off the port");
   a_standby_flags: assert property (OP_CODE == IDEC_OP_SLEEP |-> // RQ17
      UPD_TIME_OUT_POWER_DOWN && !LOAD_PC)
      else $error("standby flags wrong");
   a_watchdog_flags: assert property (OP_CODE == IDEC_OP_WDT_CLR |-> // RQ18
      UPD_TIME_OUT_POWER_DOWN && !LOAD_PC)
      else $error("watchdog clear flags wrong");
   a_skip_zero_two: assert property (s_exec_bnd and dec_r.skip_z && RESULT_ZERO |=> // RQ8
      FLUSH_NOP && OP_CODE == IDEC_OP_NOP)
      else $error("skip-on-zero did not flush");
   a_test_set_skip: assert property (s_exec_bnd and dec_r.tst_set && TESTED_BIT |=> // RQ11
      FLUSH_NOP)
      else $error("set test did not skip");
   a_literal_flags: assert property (OP_CODE inside {IDEC_OP_ADD_LW, IDEC_OP_SUB_LW} |-> // RQ14
      UPD_CARRY && UPD_DIGIT_CARRY && UPD_ZERO)
      else $error("literal arithmetic flags wrong");
   a_skip_no_flags: assert property (OP_CODE inside {IDEC_OP_INC_SZ, IDEC_OP_DEC_SZ} |-> // RQ7
      !UPD_CARRY && !UPD_DIGIT_CARRY && !UPD_ZERO)
      else $error("skip variant updates flags");
endmodule // idec_decoder

// [tb/idec_fetch_model.sv]
// Purpose: program memory and datapath feedback seen by the decoder
// Assumes: one word slot per instruction cycle, flushed cycles included
// Notes: the bench fills mem and cond while reset is held
`timescale 1ns/1ps
module idec_fetch_model (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // decoder side
   input wire logic cycle_start,
   output logic [13:0] instr_word,
   output logic result_zero,
   output logic tested_bit
);
   logic [13:0] mem [0:63];
   logic [1:0] cond [0:63];
   logic [5:0] pc_r;
   ////////////////////////////////////////////////////////////////////////////////
   // a discarded word still uses its slot, so the fetch moves on at every cycle start
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pc_r <= 6'h00;
      end else if (cycle_start) begin
         pc_r <= pc_r + 6'h01;
      end
   end
   // feedback belongs to the op on show, one slot behind the fetch
   assign instr_word = mem[pc_r];
   assign result_zero = (pc_r == 6'h00) ? 1'b0 : cond[pc_r - 6'h01][1];
   assign tested_bit = (pc_r == 6'h00) ? 1'b0 : cond[pc_r - 6'h01][0];
endmodule // idec_fetch_model

// [tb/tb_instr_decoder_14bit.sv]
// Purpose: self-checking bench of the 14-bit instruction decoder
// Assumes: every word slot, discarded or not, lasts one 4-clock cycle
// Notes: fields are worked out from the word; op and flags come from tables
`timescale 1ns/1ps
module tb_instr_decoder_14bit;
   import idec_pkg::*;
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin error_cnt++; \
   $display("Error %s expected %0h seen %0h", nm, e, g); end end
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   logic presc_on = 1'b0;
   logic [13:0] word;
   logic zero, tbit, cyc_start, flush, dest, pin, presc;
   logic upd_c, upd_dc, upd_z, upd_tp, load_pc;
   idec_op_t op;
   idec_cls_t cls;
   logic [6:0] faddr;
   logic [7:0] mask, lit;
   logic [10:0] tgt;
   int error_cnt = 0;
   int checks_done = 0;
   int cycles = 0;
   logic [13:0] wq[$];
   logic [1:0] zq[$];
   idec_op_t oq[$];
   logic [6:0] fq[$];
   always #5 core_clk = ~core_clk;
   idec_decoder DUT (
      .CORE_CLK(core_clk), .RST(rst), .INSTR_WORD(word), .RESULT_ZERO(zero),
      .TESTED_BIT(tbit), .PRESCALER_ON_TIMER(presc_on), .OP_CODE(op), .OP_CLASS(cls),
      .FILE_ADDR(faddr), .DEST_FILE(dest), .BIT_MASK(mask), .LITERAL(lit), .TARGET(tgt),
      .UPD_CARRY(upd_c), .UPD_DIGIT_CARRY(upd_dc), .UPD_ZERO(upd_z),
      .UPD_TIME_OUT_POWER_DOWN(upd_tp), .LOAD_PC(load_pc), .CYCLE_START(cyc_start),
      .FLUSH_NOP(flush), .USE_PIN_LEVELS(pin), .CLEAR_PRESCALER(presc));
   idec_fetch_model fetch (
      .clk(core_clk), .rst(rst), .cycle_start(cyc_start), .instr_word(word),
      .result_zero(zero), .tested_bit(tbit));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic close_out();
      if (error_cnt == 0 && checks_done > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   // the whole run is a few hundred cycles
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 5000) begin
         error_cnt++;
         close_out();
      end
   end
   // flags f: flush, load pc, carry, digit carry, zero, time-out/power-down, dest
   task automatic t(logic [13:0] w, logic [1:0] zb, idec_op_t o, logic [6:0] f);
      wq.push_back(w);
      zq.push_back(zb);
      oq.push_back(o);
      fq.push_back(f);
   endtask
   task automatic run();
      int n;
      logic [6:0] f;
      logic [13:0] w;
      logic wr;
      @(posedge core_clk);
      rst <= 1'b1;
      for (int i = 0; i < 64; i++) begin
         fetch.mem[i] = (i < wq.size()) ? wq[i] : 14'h0000;
         fetch.cond[i] = (i < zq.size()) ? zq[i] : 2'h0;
      end
      repeat (2) @(posedge core_clk);
      rst <= 1'b0;
      foreach (wq[i]) begin
         n = 0;
         do begin
            @(negedge core_clk);
            n++;
         end while (cyc_start !== 1'b1 && n < 9);
         if (i > 0) `CHK("cycle length", 4, n)
         f = fq[i];
         w = wq[i];
         wr = f[0] && !w[13] && !f[6];
         `CHK("op", oq[i], op)
         `CHK("flags", f, {flush, load_pc, upd_c, upd_dc, upd_z, upd_tp, dest})
         `CHK("pin levels", wr && w[6:0] == 7'h05, pin)
         `CHK("prescaler", wr && w[6:0] == 7'h01 && presc_on, presc)
         if (!f[6]) begin
            `CHK("class", w[13:12], cls)
            `CHK("file addr", w[6:0], faddr)
            `CHK("literal", w[7:0], lit)
            `CHK("target", w[10:0], tgt)
            `CHK("bit mask", (w[13:12] == 2'h1) ? 8'h01 << w[9:7] : 8'h00, mask)
         end
      end
      wq.delete();
      zq.delete();
      oq.delete();
      fq.delete();
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   task automatic sc_byte();
      t(14'h07FF, 2'h0, IDEC_OP_ADD_WF, 7'h1D);
      t(14'h0200, 2'h0, IDEC_OP_SUB_WF, 7'h1C);
      t(14'h0585, 2'h0, IDEC_OP_AND_WF, 7'h05);
      t(14'h0410, 2'h0, IDEC_OP_OR_WF, 7'h04);
      t(14'h06A0, 2'h0, IDEC_OP_XOR_WF, 7'h05);
      t(14'h0A81, 2'h0, IDEC_OP_INC_F, 7'h05);
      t(14'h0302, 2'h0, IDEC_OP_DEC_F, 7'h04);
      t(14'h0F83, 2'h0, IDEC_OP_INC_SZ, 7'h01);
      // a set tested bit must not make this one skip
      t(14'h0B04, 2'h1, IDEC_OP_DEC_SZ, 7'h00);
      t(14'h0D85, 2'h0, IDEC_OP_RL_C, 7'h11);
      t(14'h0C06, 2'h0, IDEC_OP_RR_C, 7'h10);
      t(14'h0987, 2'h0, IDEC_OP_COMP_F, 7'h05);
      t(14'h0808, 2'h0, IDEC_OP_MOVE_F, 7'h04);
      t(14'h0089, 2'h0, IDEC_OP_STORE_W, 7'h01);
      t(14'h018A, 2'h0, IDEC_OP_CLR_F, 7'h05);
      t(14'h017F, 2'h0, IDEC_OP_CLR_W, 7'h04);
      t(14'h0100, 2'h0, IDEC_OP_CLR_W, 7'h04);
      t(14'h0E8B, 2'h0, IDEC_OP_SWAP_F, 7'h01);
      t(14'h0060, 2'h0, IDEC_OP_NOP, 7'h00);
      run();
   endtask
   task automatic sc_bit();
      t(14'h100C, 2'h0, IDEC_OP_BIT_CLR, 7'h01);
      t(14'h178D, 2'h0, IDEC_OP_BIT_SET, 7'h01);
      t(14'h198E, 2'h1, IDEC_OP_TST_CLR, 7'h00);
      t(14'h1E8F, 2'h2, IDEC_OP_TST_SET, 7'h00);
      t(14'h1800, 2'h0, IDEC_OP_TST_CLR, 7'h00);
      t(14'h07FF, 2'h0, IDEC_OP_NOP, 7'h40);
      t(14'h1C7F, 2'h1, IDEC_OP_TST_SET, 7'h00);
      t(14'h0A81, 2'h0, IDEC_OP_NOP, 7'h40);
      run();
   endtask
   task automatic sc_lit();
      t(14'h38A5, 2'h0, IDEC_OP_OR_LW, 7'h04);
      t(14'h3900, 2'h0, IDEC_OP_AND_LW, 7'h04);
      t(14'h3AFF, 2'h0, IDEC_OP_XOR_LW, 7'h04);
      t(14'h3D3C, 2'h0, IDEC_OP_SUB_LW, 7'h1C);
      t(14'h3C01, 2'h0, IDEC_OP_SUB_LW, 7'h1C);
      t(14'h3F80, 2'h0, IDEC_OP_ADD_LW, 7'h1C);
      t(14'h3E7E, 2'h0, IDEC_OP_ADD_LW, 7'h1C);
      t(14'h3312, 2'h0, IDEC_OP_LOAD_LW, 7'h00);
      t(14'h3000, 2'h0, IDEC_OP_LOAD_LW, 7'h00);
      // an unlisted literal-class word falls back to a no-operation
      t(14'h3B5A, 2'h0, IDEC_OP_NOP, 7'h00);
      run();
   endtask
   // every change of flow and every true skip is followed by a discarded word
   task automatic sc_ctrl();
      t(14'h2123, 2'h0, IDEC_OP_CALL, 7'h20);
      t(14'h07FF, 2'h0, IDEC_OP_NOP, 7'h40);
      t(14'h2ABC, 2'h0, IDEC_OP_JUMP, 7'h20);
      t(14'h3FFF, 2'h0, IDEC_OP_NOP, 7'h40);
      t(14'h0008, 2'h0, IDEC_OP_RET, 7'h20);
      t(14'h0009, 2'h0, IDEC_OP_NOP, 7'h40);
      t(14'h0009, 2'h0, IDEC_OP_RET_IRQ, 7'h20);
      t(14'h1C7F, 2'h0, IDEC_OP_NOP, 7'h40);
      t(14'h3755, 2'h0, IDEC_OP_RET_LIT, 7'h20);
      t(14'h0063, 2'h0, IDEC_OP_NOP, 7'h40);
      t(14'h0063, 2'h0, IDEC_OP_SLEEP, 7'h02);
      t(14'h0064, 2'h0, IDEC_OP_WDT_CLR, 7'h02);
      t(14'h0B90, 2'h2, IDEC_OP_DEC_SZ, 7'h01);
      t(14'h38A5, 2'h0, IDEC_OP_NOP, 7'h40);
      t(14'h0F11, 2'h2, IDEC_OP_INC_SZ, 7'h00);
      t(14'h0000, 2'h0, IDEC_OP_NOP, 7'h40);
      run();
   endtask
   task automatic sc_side(logic p);
      @(posedge core_clk);
      presc_on <= p;
      t(14'h0A81, 2'h0, IDEC_OP_INC_F, 7'h05);
      t(14'h0301, 2'h0, IDEC_OP_DEC_F, 7'h04);
      t(14'h0081, 2'h0, IDEC_OP_STORE_W, 7'h01);
      t(14'h1401, 2'h0, IDEC_OP_BIT_SET, 7'h01);
      t(14'h1801, 2'h1, IDEC_OP_TST_CLR, 7'h00);
      t(14'h0085, 2'h0, IDEC_OP_STORE_W, 7'h01);
      t(14'h0805, 2'h0, IDEC_OP_MOVE_F, 7'h04);
      t(14'h1005, 2'h0, IDEC_OP_BIT_CLR, 7'h01);
      run();
   endtask
   initial begin
      repeat (6) @(posedge core_clk);
      rst <= 1'b0;
      sc_byte();
      sc_bit();
      sc_lit();
      sc_ctrl();
      sc_side(1'b0);
      sc_side(1'b1);
      close_out();
   end
endmodule // tb_instr_decoder_14bit
